// ### core/rctt_map.svh
// Register map, field positions, widths and reset values of the RC trim tuner
`ifndef RCTT_MAP_SVH
`define RCTT_MAP_SVH

// Word offsets on the bus
`define RCTT_OFS_SYS_TRIM   8'h00
`define RCTT_OFS_FAST_CFG   8'h04
`define RCTT_OFS_FAST_STS   8'h08
`define RCTT_OFS_IRQ_STS    8'h0C
`define RCTT_OFS_IRQ_MASK   8'h10

// Field widths
`define RCTT_SYS_TRIM_W     10
`define RCTT_FAST_TRIM_W    7
`define RCTT_MARGIN_W       4
`define RCTT_NBP_W          3
`define RCTT_CERR_W         5
`define RCTT_CNT_W          17
`define RCTT_PCNT_W         8
`define RCTT_IRQ_W          3

// system_rc_trim fields
`define RCTT_SYS_TRIM_LSB   0
`define RCTT_SYS_FCD        16

// fast_rc_config fields
`define RCTT_CFG_EN         0
`define RCTT_CFG_TUNE       1
`define RCTT_CFG_JIT        2
`define RCTT_CFG_NBP_LSB    4
`define RCTT_CFG_FCD        7
`define RCTT_CFG_RNG_LSB    8
`define RCTT_CFG_MARGIN_LSB 12
`define RCTT_CFG_TRIM_LSB   16
`define RCTT_CFG_TRIM_BYTE  2

// fast_rc_tuner_status fields
`define RCTT_STS_TRIM_LSB   0
`define RCTT_STS_CERR_LSB   16
`define RCTT_STS_SIGN       21
`define RCTT_STS_LOCK       24
`define RCTT_STS_LOST       25
`define RCTT_STS_UPD        31

// Interrupt status bits
`define RCTT_IRQ_DONE       0
`define RCTT_IRQ_LOCK       1
`define RCTT_IRQ_LOST       2

// Reset values
`define RCTT_CFG_RST        32'h00000000
`define RCTT_STS_RST        32'h00000000

// Base count per reference period
`define RCTT_THEOR_BASE     17'h0007A

`endif

// ### core/rctt_pkg.sv
// Types shared by the RC trim tuner
package rctt_pkg;
`include "rctt_map.svh"

   // Measurement sequencer
   typedef enum logic [3:0] {
      RCTT_ST_IDLE  = 4'b0001,
      RCTT_ST_SYNC  = 4'b0010,
      RCTT_ST_COUNT = 4'b0100,
      RCTT_ST_EVAL  = 4'b1000
   } rctt_state_e;

   // Whole state of the tuner
   typedef struct packed {
      logic                          wb_ack;
      logic [31:0]                   wb_dat;
      logic [`RCTT_SYS_TRIM_W-1:0]   sys_trim;
      logic                          sys_fcd;
      logic                          fast_load;
      logic                          en;
      logic                          tune;
      logic                          jit;
      logic [`RCTT_NBP_W-1:0]        nbp;
      logic [1:0]                    rng;
      logic [`RCTT_MARGIN_W-1:0]     margin;
      logic [`RCTT_FAST_TRIM_W-1:0]  trim;
      rctt_state_e                   st;
      logic [`RCTT_PCNT_W-1:0]       pcnt;
      logic [`RCTT_CNT_W-1:0]        fcnt;
      logic                          upd;
      logic                          lock;
      logic                          lost;
      logic                          sign;
      logic [`RCTT_CERR_W-1:0]       cerr;
      logic [`RCTT_FAST_TRIM_W-1:0]  cur_trim;
      logic [`RCTT_IRQ_W-1:0]        ists;
      logic [`RCTT_IRQ_W-1:0]        imask;
      logic                          irq;
      logic [2:0]                    ref_s;
      logic [2:0]                    fast_s;
   } rctt_state_s;

endpackage

// ### core/rctt_top.sv
// RC oscillator trim registers and closed-loop fast oscillator tuner
`timescale 1ns/10ps

module rctt_top
   import rctt_pkg::*;
(
   // Clock and resets
   input  wire logic                          i_clk,
   input  wire logic                          i_srst,
   input  wire logic                          i_por_rst,
   // Wishbone slave
   input  wire logic                          i_wb_cyc,
   input  wire logic                          i_wb_stb,
   input  wire logic                          i_wb_we,
   input  wire logic [7:0]                    i_wb_adr,
   input  wire logic [3:0]                    i_wb_sel,
   input  wire logic [31:0]                   i_wb_dat,
   output logic      [31:0]                   o_wb_dat,
   output logic                               o_wb_ack,
   // Fuse values
   input  wire logic [`RCTT_SYS_TRIM_W-1:0]   i_sys_fuse_trim,
   input  wire logic [`RCTT_FAST_TRIM_W-1:0]  i_fast_fuse_trim,
   // Clocks to be measured, asynchronous
   input  wire logic                          i_ref_32k,
   input  wire logic                          i_fast_osc,
   // Oscillator controls
   output logic      [`RCTT_SYS_TRIM_W-1:0]   o_sys_trim,
   output logic      [`RCTT_FAST_TRIM_W-1:0]  o_fast_trim,
   output logic      [1:0]                    o_fast_range,
   output logic                               o_fast_osc_en,
   // Status and interrupt
   output logic                               o_locked,
   output logic                               o_unlocked,
   output logic                               o_irq
);

   rctt_state_s q;
   rctt_state_s d;

   // Byte-lane merge of a write into a register image
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel
   );
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Expected fast cycles over the window
   function automatic logic [`RCTT_CNT_W-1:0] theor_count(
      input logic [1:0]             rng,
      input logic [`RCTT_NBP_W-1:0] nbp
   );
      logic [`RCTT_CNT_W-1:0] base;
      base = `RCTT_THEOR_BASE * ({15'h0000, rng} + 17'h00001);
      return base << nbp;
   endfunction

   // Read images of each register
   logic [31:0] sys_img;
   logic [31:0] cfg_img;
   logic [31:0] sts_img;
   logic [31:0] ists_img;
   logic [31:0] imask_img;

   // Register images built from state
   always_comb begin
      sys_img = 32'h00000000;
      sys_img[`RCTT_SYS_TRIM_LSB +: `RCTT_SYS_TRIM_W] = q.sys_trim;
      sys_img[`RCTT_SYS_FCD] = q.sys_fcd;
      cfg_img = `RCTT_CFG_RST;
      cfg_img[`RCTT_CFG_EN] = q.en;
      cfg_img[`RCTT_CFG_TUNE] = q.tune;
      cfg_img[`RCTT_CFG_JIT] = q.jit;
      cfg_img[`RCTT_CFG_NBP_LSB +: `RCTT_NBP_W] = q.nbp;
      cfg_img[`RCTT_CFG_FCD] = 1'b1;
      cfg_img[`RCTT_CFG_RNG_LSB +: 2] = q.rng;
      cfg_img[`RCTT_CFG_MARGIN_LSB +: `RCTT_MARGIN_W] = q.margin;
      cfg_img[`RCTT_CFG_TRIM_LSB +: `RCTT_FAST_TRIM_W] = q.trim;
      sts_img = `RCTT_STS_RST;
      sts_img[`RCTT_STS_TRIM_LSB +: `RCTT_FAST_TRIM_W] = q.cur_trim;
      sts_img[`RCTT_STS_CERR_LSB +: `RCTT_CERR_W] = q.cerr;
      sts_img[`RCTT_STS_SIGN] = q.sign;
      sts_img[`RCTT_STS_LOCK] = q.lock;
      sts_img[`RCTT_STS_LOST] = q.lost;
      sts_img[`RCTT_STS_UPD] = q.upd;
      ists_img = 32'h00000000;
      ists_img[`RCTT_IRQ_W-1:0] = q.ists;
      imask_img = 32'h00000000;
      imask_img[`RCTT_IRQ_W-1:0] = q.imask;
   end

   // Working values of the next-state logic
   logic                         bus_go;
   logic                         wr_go;
   logic                         rd_go;
   logic [31:0]                  wv;
   logic                         trim_wr;
   logic                         ref_rise;
   logic                         fast_rise;
   logic [`RCTT_CNT_W-1:0]       theor;
   logic [`RCTT_CNT_W-1:0]       abs_err;
   logic                         cnt_high;
   logic                         in_margin;
   logic [`RCTT_PCNT_W-1:0]      pcnt_nx;
   logic [`RCTT_PCNT_W-1:0]      win_len;
   logic [`RCTT_IRQ_W-1:0]       ev;
   logic [`RCTT_FAST_TRIM_W-1:0] trim_max;

   // Next-state logic of the whole block
   always_comb begin
      d = q;
      wv = 32'h00000000;
      trim_wr = 1'b0;
      ev = '0;
      trim_max = '1;
      bus_go = i_wb_cyc & i_wb_stb & ~q.wb_ack;
      wr_go = bus_go & i_wb_we;
      rd_go = bus_go & ~i_wb_we;

      // Edge detect reads only the second and third stages
      d.ref_s = {q.ref_s[1:0], i_ref_32k};
      d.fast_s = {q.fast_s[1:0], i_fast_osc};
      ref_rise = q.ref_s[1] & ~q.ref_s[2];
      fast_rise = q.fast_s[1] & ~q.fast_s[2];

      // Comparison against the expected count
      theor = theor_count(q.rng, q.nbp);
      cnt_high = q.fcnt > theor;
      abs_err = cnt_high ? (q.fcnt - theor) : (theor - q.fcnt);
      in_margin = abs_err <= {13'h0000, q.margin};
      win_len = {{(`RCTT_PCNT_W-1){1'b0}}, 1'b1} << q.nbp;
      pcnt_nx = q.pcnt + 8'h01;

      // Single-cycle Wishbone answer
      d.wb_ack = bus_go;
      d.wb_dat = 32'h00000000;
      if (rd_go) begin
         case (i_wb_adr)
            `RCTT_OFS_SYS_TRIM: d.wb_dat = sys_img;
            `RCTT_OFS_FAST_CFG: d.wb_dat = cfg_img;
            `RCTT_OFS_FAST_STS: d.wb_dat = sts_img;
            `RCTT_OFS_IRQ_STS:  d.wb_dat = ists_img;
            `RCTT_OFS_IRQ_MASK: d.wb_dat = imask_img;
            default:            d.wb_dat = 32'h00000000;
         endcase
      end

      // Register writes; unmapped offsets are ignored
      if (wr_go) begin
         case (i_wb_adr)
            `RCTT_OFS_SYS_TRIM: begin
               wv = lane_merge(sys_img, i_wb_dat, i_wb_sel);
               d.sys_trim = wv[`RCTT_SYS_TRIM_LSB +: `RCTT_SYS_TRIM_W];
            end
            `RCTT_OFS_FAST_CFG: begin
               wv = lane_merge(cfg_img, i_wb_dat, i_wb_sel);
               d.en = wv[`RCTT_CFG_EN];
               d.tune = wv[`RCTT_CFG_TUNE];
               d.jit = wv[`RCTT_CFG_JIT];
               d.nbp = wv[`RCTT_CFG_NBP_LSB +: `RCTT_NBP_W];
               d.rng = wv[`RCTT_CFG_RNG_LSB +: 2];
               d.margin = wv[`RCTT_CFG_MARGIN_LSB +: `RCTT_MARGIN_W];
               trim_wr = i_wb_sel[`RCTT_CFG_TRIM_BYTE];
            end
            `RCTT_OFS_IRQ_MASK: begin
               wv = lane_merge(imask_img, i_wb_dat, i_wb_sel);
               d.imask = wv[`RCTT_IRQ_W-1:0];
            end
            default: begin
               wv = 32'h00000000;
            end
         endcase
      end
      if (trim_wr) begin
         d.trim = wv[`RCTT_CFG_TRIM_LSB +: `RCTT_FAST_TRIM_W];
      end

      // Fast trim taken from the fuses once after every reset
      if (q.fast_load) begin
         d.trim = i_fast_fuse_trim;
         d.fast_load = 1'b0;
      end
      // System trim loaded only while the fuse-done flag is clear
      if (!q.sys_fcd) begin
         d.sys_trim = i_sys_fuse_trim;
         d.sys_fcd = 1'b1;
      end

      // Measurement sequencer
      case (q.st)
         RCTT_ST_IDLE: begin
            if (q.en && q.tune) begin
               d.st = RCTT_ST_SYNC;
            end
         end
         RCTT_ST_SYNC: begin
            d.pcnt = '0;
            d.fcnt = '0;
            if (ref_rise) begin
               d.st = RCTT_ST_COUNT;
            end
         end
         RCTT_ST_COUNT: begin
            // Saturate so a runaway clock cannot wrap into lock
            if (fast_rise && (q.fcnt != '1)) begin
               d.fcnt = q.fcnt + 17'h00001;
            end
            if (ref_rise) begin
               d.pcnt = pcnt_nx;
               if (pcnt_nx == win_len) begin
                  d.st = RCTT_ST_EVAL;
               end
            end
         end
         RCTT_ST_EVAL: begin
            d.st = RCTT_ST_SYNC;
            d.lock = in_margin;
            d.lost = ~in_margin;
            d.sign = ~cnt_high & (abs_err != '0);
            d.cerr = (abs_err > 17'h0001F) ? '1 : abs_err[`RCTT_CERR_W-1:0];
            d.upd = ~q.upd;
            d.cur_trim = q.trim;
            // Hold trim while locked unless continuous mode; a software trim write wins
            if ((q.jit || !in_margin) && !trim_wr) begin
               if (cnt_high && (q.trim != trim_max)) begin
                  d.trim = q.trim + 7'h01;
               end else if (!cnt_high && (abs_err != '0) && (q.trim != '0)) begin
                  d.trim = q.trim - 7'h01;
               end
               d.cur_trim = d.trim;
            end
            ev[`RCTT_IRQ_DONE] = 1'b1;
            ev[`RCTT_IRQ_LOCK] = in_margin;
            ev[`RCTT_IRQ_LOST] = ~in_margin;
         end
         default: begin
            d.st = RCTT_ST_IDLE;
         end
      endcase

      // Leaving closed loop or a fresh trim aborts the window
      if (!q.en || !q.tune) begin
         d.st = RCTT_ST_IDLE;
      end else if (trim_wr) begin
         d.st = RCTT_ST_SYNC;
      end

      // Sticky events, read clears, a new event wins
      if (rd_go && (i_wb_adr == `RCTT_OFS_IRQ_STS)) begin
         d.ists = ev;
      end else begin
         d.ists = q.ists | ev;
      end
      d.irq = |(d.ists & d.imask);

      // Synchronous resets; a set fuse-done flag survives a plain reset
      if (i_srst || i_por_rst) begin
         d = '0;
         d.st = RCTT_ST_IDLE;
         d.fast_load = 1'b1;
         d.ref_s = q.ref_s;
         d.fast_s = q.fast_s;
         if (!i_por_rst && q.sys_fcd) begin
            d.sys_fcd = 1'b1;
            d.sys_trim = q.sys_trim;
         end
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      q <= d;
   end

   // Outputs straight from the state register
   assign o_wb_dat = q.wb_dat;
   assign o_wb_ack = q.wb_ack;
   assign o_sys_trim = q.sys_trim;
   assign o_fast_trim = q.trim;
   assign o_fast_range = q.rng;
   assign o_fast_osc_en = q.en;
   assign o_locked = q.lock;
   assign o_unlocked = q.lost;
   assign o_irq = q.irq;

endmodule // rctt_top

// ### sim/rctt_chk_sva.sv
// Port checker for the RC trim tuner
`timescale 1ns/10ps
`include "rctt_map.svh"
module rctt_chk
   import rctt_pkg::*;
(
   // Clock and resets
   input wire logic                         i_clk,
   input wire logic                         i_srst,
   input wire logic                         i_por_rst,
   // Bus
   input wire logic                         i_wb_cyc,
   input wire logic                         i_wb_stb,
   input wire logic                         i_wb_we,
   input wire logic [7:0]                   i_wb_adr,
   input wire logic [3:0]                   i_wb_sel,
   input wire logic [31:0]                  i_wb_dat,
   input wire logic [31:0]                  o_wb_dat,
   input wire logic                         o_wb_ack,
   // Fuses and outputs
   input wire logic [`RCTT_SYS_TRIM_W-1:0]  i_sys_fuse_trim,
   input wire logic [`RCTT_FAST_TRIM_W-1:0] i_fast_fuse_trim,
   input wire logic [`RCTT_SYS_TRIM_W-1:0]  o_sys_trim,
   input wire logic [`RCTT_FAST_TRIM_W-1:0] o_fast_trim,
   input wire logic [1:0]                   o_fast_range,
   input wire logic                         o_fast_osc_en,
   input wire logic                         o_locked,
   input wire logic                         o_unlocked,
   input wire logic                         o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst || i_por_rst);
   // Request taken, then a config write
   sequence s_take;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_wcfg;
      s_take ##0 i_wb_we && i_wb_adr == `RCTT_OFS_FAST_CFG;
   endsequence
   property p_ack;
      s_take |=> o_wb_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack_drop;
      o_wb_ack |=> !o_wb_ack;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack held");
   property p_dat_idle;
      !o_wb_ack |-> o_wb_dat == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
   property p_excl;
      !(o_locked && o_unlocked);
   endproperty
   a_excl: assert property (p_excl) else $error("lock flags both set");
   property p_en;
      s_wcfg ##0 i_wb_sel[0] |=> o_fast_osc_en == $past(i_wb_dat[`RCTT_CFG_EN]);
   endproperty
   a_en: assert property (p_en) else $error("enable not applied");
   property p_trim;
      s_wcfg ##0 i_wb_sel[2] |=> o_fast_trim == $past(i_wb_dat[22:16]);
   endproperty
   a_trim: assert property (p_trim) else $error("trim not applied");
   property p_rng;
      s_wcfg ##0 i_wb_sel[1] |=> o_fast_range == $past(i_wb_dat[9:8]);
   endproperty
   a_rng: assert property (p_rng) else $error("range not applied");
   property p_load;
      $fell(i_por_rst) |=> o_sys_trim == $past(i_sys_fuse_trim)
         && o_fast_trim == $past(i_fast_fuse_trim);
   endproperty
   a_load: assert property (p_load) else $error("fuse load missing");
   // Fuse-done set, so a plain reset must not reload
   property p_keep;
      @(posedge i_clk) disable iff (i_por_rst)
         $rose(i_srst) && !$past(i_por_rst) |=> $stable(o_sys_trim) [*3];
   endproperty
   a_keep: assert property (p_keep) else $error("trim reloaded");
   property p_por;
      @(posedge i_clk) disable iff (1'b0)
         i_por_rst |=> o_sys_trim == '0 && !o_fast_osc_en && !o_irq;
   endproperty
   a_por: assert property (p_por) else $error("reset outputs");
endmodule // rctt_chk

bind rctt_top rctt_chk chk_u (.*);

// ### sim/rctt_osc_model.sv
// Behavioural fast RC core and 32 kHz reference
`timescale 1ns/10ps
`include "rctt_map.svh"
module rctt_osc_model (
   // Controls from the tuner
   input  wire logic [`RCTT_FAST_TRIM_W-1:0] i_trim,
   input  wire logic [1:0]                   i_range,
   input  wire logic                         i_en,
   // Clocks to the tuner
   output logic                              o_ref_32k,
   output logic                              o_fast_osc
);
   // Reference runs free
   initial begin
      o_ref_32k = 1'b0;
      forever #15258.79 o_ref_32k = ~o_ref_32k;
   end
   // Period tracks trim live; output parks low when disabled
   initial begin
      o_fast_osc = 1'b0;
      forever begin
         if (i_en) begin
            #((100.0 + i_trim) / (1.0 + i_range)) o_fast_osc = ~o_fast_osc;
         end else begin
            o_fast_osc = 1'b0;
            @(i_en);
         end
      end
   end
endmodule // rctt_osc_model

// ### sim/rctt_top_bench.sv
// Self-checking bench of the RC trim tuner
`timescale 1ns/10ps
`include "rctt_map.svh"
module rctt_top_bench;
   // Design ports
   logic        i_clk, i_srst, i_por_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_ref_32k;
   logic        i_fast_osc, o_wb_ack, o_fast_osc_en, o_locked, o_unlocked, o_irq;
   logic [7:0]  i_wb_adr;
   logic [3:0]  i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat, rdat;
   logic [9:0]  i_sys_fuse_trim, o_sys_trim;
   logic [6:0]  i_fast_fuse_trim, o_fast_trim, pt;
   logic [1:0]  o_fast_range, rng;
   logic [3:0]  mar;
   logic [2:0]  n;
   logic        jit, pu = 1'b0;
   int          error_cnt = 0, cmp_count = 0;
   rctt_top dut_u (.*);
   rctt_osc_model osc_u (.i_trim(o_fast_trim), .i_range(o_fast_range),
      .i_en(o_fast_osc_en), .o_ref_32k(i_ref_32k), .o_fast_osc(i_fast_osc));
   // 125 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_dat <= d;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_wb_ack !== 1'b1);
      chk(k, 32'd2);
      rdat = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rst(input logic por);
      i_por_rst <= por;
      i_srst <= 1'b1;
      repeat (5) @(posedge i_clk);
      i_por_rst <= 1'b0;
      i_srst <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask
   // Writes the tuner setup, which restarts any window
   task automatic cfg();
      wb(1'b1, `RCTT_OFS_FAST_CFG, {9'h0, pt, mar, 2'b0, rng, 1'b0, n, 1'b0, jit, 2'b11});
      wb(1'b0, `RCTT_OFS_IRQ_STS, 32'h0);
      chk(o_fast_range, rng);
   endtask
   // Waits one procedure; expectations come from the core model's period
   task automatic proc();
      real c, e;
      int  t, k;
      k = 0;
      while (o_irq !== 1'b1 && k < 40000) begin
         @(posedge i_clk);
         k++;
      end
      wb(1'b0, `RCTT_OFS_IRQ_STS, 32'h0);
      chk(rdat[`RCTT_IRQ_DONE], 1'b1);
      wb(1'b0, `RCTT_OFS_FAST_STS, 32'h0);
      c = 30517.58 * (1 << n) * (1 + rng) / (200.0 + 2 * pt);
      t = 122 * (1 + rng) << n;
      e = (c > t) ? c - t : t - c;
      chk(rdat[20:16] >= e - 1.5 && rdat[20:16] <= e + 1.5, 1'b1);
      if (e > 1.5) chk(rdat[21], c < t);
      chk(rdat[24], rdat[20:16] <= mar);
      chk(rdat[25], rdat[20:16] > mar);
      chk(o_locked, rdat[24]);
      chk(o_unlocked, rdat[25]);
      chk(rdat[31], !pu);
      pu = rdat[31];
      t = pt;
      if (rdat[20:16] != 0 && (jit || rdat[25])) t = rdat[21] ? pt - 1 : pt + 1;
      chk(rdat[6:0], t);
      chk(o_fast_trim, t);
      pt = rdat[6:0];
   endtask
   task automatic t_regs();
      chk(o_sys_trim, 10'h2A5);
      wb(1'b0, `RCTT_OFS_SYS_TRIM, 32'h0);
      chk(rdat, 32'h000102A5);
      wb(1'b0, `RCTT_OFS_FAST_CFG, 32'h0);
      chk(rdat, 32'h00330080);
      wb(1'b0, `RCTT_OFS_FAST_STS, 32'h0);
      chk(rdat, 32'h00000000);
      wb(1'b0, 8'h14, 32'h0);
      chk(rdat, 32'h00000000);
      wb(1'b1, `RCTT_OFS_SYS_TRIM, 32'h00000155);
      i_sys_fuse_trim <= 10'h0F0;
      rst(1'b0);
      chk(o_sys_trim, 10'h155);
      rst(1'b1);
      chk(o_sys_trim, 10'h0F0);
      $display("test regs done");
   endtask
   // Open loop: trim stays put, no procedure ends
   task automatic t_open();
      wb(1'b1, `RCTT_OFS_IRQ_MASK, 32'h1);
      wb(1'b1, `RCTT_OFS_FAST_CFG, 32'h00140001);
      chk(o_fast_osc_en, 1'b1);
      chk(o_fast_trim, 7'h14);
      repeat (4000) @(posedge i_clk);
      chk(o_fast_trim, 7'h14);
      chk(o_irq, 1'b0);
      wb(1'b1, `RCTT_OFS_FAST_CFG, 32'h0);
      chk(o_fast_osc_en, 1'b0);
      $display("test open loop done");
   endtask
   task automatic t_tune();
      rng = 2'd0;
      n = 3'd0;
      jit = 1'b0;
      mar = 4'h3;
      pt = 7'd21;
      cfg();
      repeat (4) proc();
      // Masked event waits, then shows on unmask
      wb(1'b1, `RCTT_OFS_IRQ_MASK, 32'h0);
      repeat (9000) @(posedge i_clk);
      chk(o_irq, 1'b0);
      wb(1'b1, `RCTT_OFS_IRQ_MASK, 32'h1);
      chk(o_irq, 1'b1);
      // Exactly one procedure ran unseen while masked, so the toggle moved once
      pu = !pu;
      pt = 7'd30;
      cfg();
      proc();
      $display("test closed loop done");
   endtask
   task automatic t_range();
      jit = 1'b1;
      for (int r = 0; r < 3; r++) begin
         rng = r[1:0];
         n = r[2:0];
         pt = 7'd25;
         cfg();
         proc();
      end
      $display("test ranges done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= '0;
      i_wb_sel <= 4'hF;
      i_sys_fuse_trim <= 10'h2A5;
      i_fast_fuse_trim <= 7'h33;
      rst(1'b1);
      t_regs();
      t_open();
      t_tune();
      t_range();
      conclude();
   end
   // Hang guard, a little above the expected run
   initial begin
      repeat (98000) @(posedge i_clk);
      error_cnt++;
      conclude();
   end
endmodule // rctt_top_bench
